/* ssc_ctrl.sv */
// Suspend handshake, system management entry and serial status sender.
`default_nettype none

module ssc_ctrl (
  // Clock, reset and clock enable.
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            clk_en,
  // Configuration levels.
  input  wire logic            suspend_pin_enable,
  input  wire logic            halt_to_suspend,
  input  wire logic            stop_all_clocks,
  // Pins from the system.
  input  wire logic            sys_mgmt_irq_n,
  input  wire logic            suspend_req_n,
  // Core handshake.
  input  wire logic            halt_exec,
  input  wire logic            core_idle,
  input  wire logic            wake_evt,
  input  wire logic            smm_exit,
  output logic                 sys_mgmt_mode,
  // Clock control and suspend acknowledge pin.
  output logic                 core_clk_stop,
  output logic                 all_clk_stop,
  output logic                 ext_clk_stop_ok,
  output logic                 suspend_ack_n_o,
  output logic                 suspend_ack_n_oe_n,
  // Status packet stream and serial wire.
  input  wire ssc_pkg::ssc_pkt_t pkt_data,
  input  wire logic            pkt_valid,
  output logic                 pkt_ready,
  output logic                 serial_packet_out
);
  import ssc_pkg::*;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [1:0] pin_s1_ff, pin_s2_ff, nxt_pin_s1, nxt_pin_s2;
  logic       smi_low, req_low;

  always_comb begin
    nxt_pin_s1 = pin_s1_ff;
    nxt_pin_s2 = pin_s2_ff;
    if (clk_en) begin
      nxt_pin_s1 = {suspend_req_n, sys_mgmt_irq_n};
      nxt_pin_s2 = pin_s1_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_ff <= {PIN_IDLE_N, PIN_IDLE_N};
      pin_s2_ff <= {PIN_IDLE_N, PIN_IDLE_N};
    end else begin
      pin_s1_ff <= nxt_pin_s1;
      pin_s2_ff <= nxt_pin_s2;
    end
  end

  assign smi_low = ~pin_s2_ff[0];
  assign req_low = ~pin_s2_ff[1];

  // ********************************************************************
  // System management mode
  // ********************************************************************
  logic smm_ff, nxt_smm;
  always_comb begin
    nxt_smm = smm_ff;
    if (clk_en) begin
      if (smm_ff && smm_exit) begin
        nxt_smm = 1'b0;
      end else if (smi_low) begin
        // Held low after an exit, the level re-enters the mode.
        nxt_smm = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smm_ff <= 1'b0;
    end else begin
      smm_ff <= nxt_smm;
    end
  end

  assign sys_mgmt_mode = smm_ff;

  // ********************************************************************
  // Suspend sequencer
  // ********************************************************************
  ssc_state_t st_ff, nxt_st;
  logic       by_pin_ff, nxt_by_pin;
  logic       ack_n_ff, nxt_ack_n;
  logic       oe_n_ff, nxt_oe_n;
  logic       core_stop_ff, nxt_core_stop;
  logic       all_stop_ff, nxt_all_stop;
  logic       req_ok;
  assign req_ok = suspend_pin_enable & req_low;
  always_comb begin
    nxt_st        = st_ff;
    nxt_by_pin    = by_pin_ff;
    nxt_ack_n     = ack_n_ff;
    nxt_oe_n      = oe_n_ff;
    nxt_core_stop = core_stop_ff;
    nxt_all_stop  = all_stop_ff;
    if (clk_en) begin
      case (st_ff)
        SSC_RUN: begin
          if (halt_exec && halt_to_suspend) begin
            nxt_st     = SSC_SUSPEND_REQ_N;
            nxt_by_pin = 1'b0;
          end else if (req_ok) begin
            nxt_st     = SSC_DRAIN;
            nxt_by_pin = 1'b1;
          end
        end
        SSC_DRAIN: begin
          if (core_idle) begin
            nxt_st = SSC_SUSPEND_REQ_N;
          end
        end
        SSC_SUSPEND_REQ_N: begin
          if (by_pin_ff ? !req_low : wake_evt) begin
            nxt_st = SSC_RUN;
          end
        end
        default: nxt_st = SSC_RUN;
      endcase
      nxt_ack_n     = (nxt_st != SSC_SUSPEND_REQ_N);
      nxt_oe_n      = ~suspend_pin_enable;
      nxt_core_stop = (nxt_st == SSC_SUSPEND_REQ_N);
      nxt_all_stop  = (nxt_st == SSC_SUSPEND_REQ_N) && stop_all_clocks;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff        <= SSC_RUN;
      by_pin_ff    <= 1'b0;
      ack_n_ff     <= PIN_IDLE_N;
      oe_n_ff      <= 1'b1;
      core_stop_ff <= 1'b0;
      all_stop_ff  <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      by_pin_ff    <= nxt_by_pin;
      ack_n_ff     <= nxt_ack_n;
      oe_n_ff      <= nxt_oe_n;
      core_stop_ff <= nxt_core_stop;
      all_stop_ff  <= nxt_all_stop;
    end
  end

  assign suspend_ack_n_o    = ack_n_ff;
  assign suspend_ack_n_oe_n = oe_n_ff;
  assign core_clk_stop      = core_stop_ff;
  assign all_clk_stop       = all_stop_ff;
  // The system may stop its clock only in full-stop suspend with ack out.
  assign ext_clk_stop_ok = all_stop_ff & ~ack_n_ff & ~oe_n_ff;

  // ********************************************************************
  // Two-entry packet buffer
  // ********************************************************************
  ssc_pkt_t   buf_ff [2];
  ssc_pkt_t   nxt_buf [2];
  logic       wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic [1:0] cnt_ff, nxt_cnt;
  logic       buf_valid, buf_pop, buf_push;
  assign pkt_ready = (cnt_ff != BUF_FULL_CNT) & clk_en;
  assign buf_valid = (cnt_ff != BUF_EMPTY);
  assign buf_push  = pkt_valid & pkt_ready;

  for (genvar e = 0; e < 2; e++) begin : g_entry
    always_comb begin
      nxt_buf[e] = buf_ff[e];
      if (buf_push && (wr_ptr_ff == 1'(e))) begin
        nxt_buf[e] = pkt_data;
      end
    end
  end

  always_comb begin
    nxt_wr_ptr = wr_ptr_ff ^ buf_push;
    nxt_rd_ptr = rd_ptr_ff ^ buf_pop;
    nxt_cnt    = cnt_ff;
    if (buf_push && !buf_pop) begin
      nxt_cnt = cnt_ff + BUF_ONE;
    end else if (!buf_push && buf_pop) begin
      nxt_cnt = cnt_ff - BUF_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= BUF_EMPTY;
    end else begin
      buf_ff    <= nxt_buf;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end

  // ********************************************************************
  // Serial sender
  // ********************************************************************
  logic [PKT_W-1:0] sh_ff, nxt_sh;
  logic [3:0]       bits_ff, nxt_bits;
  logic             ser_ff, nxt_ser;

  // A packet is taken only when the wire is idle, which stalls the buffer.
  assign buf_pop = clk_en & buf_valid & (bits_ff == SER_CNT_ZERO);

  always_comb begin
    nxt_sh   = sh_ff;
    nxt_bits = bits_ff;
    nxt_ser  = ser_ff;
    if (buf_pop) begin
      nxt_sh   = buf_ff[rd_ptr_ff];
      nxt_bits = SER_FRAME_BITS;
      nxt_ser  = SER_START_BIT;
    end else if (clk_en && (bits_ff != SER_CNT_ZERO)) begin
      nxt_bits = bits_ff - SER_CNT_ONE;
      nxt_ser  = (bits_ff == SER_CNT_ONE) ? SER_IDLE_BIT : sh_ff[0];
      nxt_sh   = sh_ff >> 1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sh_ff   <= '0;
      bits_ff <= SER_CNT_ZERO;
      ser_ff  <= SER_IDLE_BIT;
    end else begin
      sh_ff   <= nxt_sh;
      bits_ff <= nxt_bits;
      ser_ff  <= nxt_ser;
    end
  end

  assign serial_packet_out = ser_ff;

  // ********************************************************************
  // Checks
  // ********************************************************************
  AST_SMI_ENTER: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && smi_low && !smm_ff |=> smm_ff) else $error("mode not entered");
  AST_SMI_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(smm_ff) |-> $past(smi_low)) else $error("entry without low level");
  AST_PIN_IGNORED: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff == SSC_RUN && !suspend_pin_enable |=> st_ff != SSC_DRAIN)
    else $error("suspend request taken while pin disabled");
  AST_DRAIN_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff == SSC_DRAIN && !core_idle |=> st_ff == SSC_DRAIN)
    else $error("suspend entered before core drained");
  AST_HALT_SUSPEND_REQ_N: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && st_ff == SSC_RUN && halt_exec && halt_to_suspend
    |=> st_ff == SSC_SUSPEND_REQ_N ##0 !suspend_ack_n_o) else $error("halt not taken");
  AST_ACK_MATCH: assert property (@(posedge clk) disable iff (sys_rst)
    !suspend_ack_n_o |-> st_ff == SSC_SUSPEND_REQ_N && core_clk_stop)
    else $error("acknowledge low outside suspend");
  AST_ACK_FLOAT: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !suspend_pin_enable |=> suspend_ack_n_oe_n)
    else $error("acknowledge driven while pin disabled");
  AST_ALL_STOP: assert property (@(posedge clk) disable iff (sys_rst)
    all_clk_stop |-> core_clk_stop && !suspend_ack_n_o)
    else $error("all clocks stopped outside suspend");
  AST_RESUME: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && st_ff == SSC_SUSPEND_REQ_N && by_pin_ff && !req_low
    |=> suspend_ack_n_o && st_ff == SSC_RUN) else $error("ack not released");
  AST_SER_FRAME: assert property (@(posedge clk) disable iff (sys_rst)
    buf_pop |=> serial_packet_out && bits_ff == SER_FRAME_BITS)
    else $error("serial frame did not start with start bit");

endmodule : ssc_ctrl

`default_nettype wire

/* ssc_pkg.sv */
// Shared types and constants of the suspend and system management control.
`default_nettype none

package ssc_pkg;

  // ********************************************************************
  // Packet carried on the serial wire
  // ********************************************************************
  localparam int unsigned PKT_W = 8;

  typedef struct packed {
    logic [3:0] kind;
    logic [3:0] info;
  } ssc_pkt_t;

  // ********************************************************************
  // Serial framing
  // ********************************************************************
  // One start bit, then the packet with the least significant bit first.
  localparam logic [3:0] SER_FRAME_BITS = 4'h9;
  localparam logic [3:0] SER_CNT_ZERO   = 4'h0;
  localparam logic [3:0] SER_CNT_ONE    = 4'h1;
  localparam logic       SER_START_BIT  = 1'b1;
  localparam logic       SER_IDLE_BIT   = 1'b0;

  // ********************************************************************
  // Two-entry packet buffer
  // ********************************************************************
  localparam logic [1:0] BUF_FULL_CNT = 2'h2;
  localparam logic [1:0] BUF_EMPTY    = 2'h0;
  localparam logic [1:0] BUF_ONE      = 2'h1;

  // ********************************************************************
  // Suspend sequencer states and reset values
  // ********************************************************************
  typedef enum logic [2:0] {
    SSC_RUN   = 3'b001,
    SSC_DRAIN = 3'b010,
    SSC_SUSPEND_REQ_N  = 3'b100
  } ssc_state_t;

  localparam logic PIN_IDLE_N = 1'b1;

endpackage : ssc_pkg

`default_nettype wire

/* ssc_rx_model.sv */
// Companion chipset side: decodes serial status frames from the wire.
`default_nettype none

module ssc_rx_model (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Serial wire in, decoded packet out.
  input  wire logic              serial_in,
  output ssc_pkg::ssc_pkt_t      pkt_out,
  output logic                   pkt_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssc_pkg::*;

  logic [3:0] bit_cnt;
  logic [7:0] shift;

  // A start bit opens a frame; eight bits follow, first one lowest.
  always @(posedge clk) begin
    pkt_strobe <= 1'b0;
    if (sys_rst) begin
      bit_cnt <= 4'h0;
    end else if (bit_cnt == 4'h0) begin
      if (serial_in === SER_START_BIT) begin
        bit_cnt <= 4'h1;
      end
    end else begin
      shift <= {serial_in, shift[7:1]};
      if (bit_cnt == 4'h8) begin
        pkt_out    <= ssc_pkt_t'({serial_in, shift[7:1]});
        pkt_strobe <= 1'b1;
        bit_cnt    <= 4'h0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end
endmodule // ssc_rx_model

`default_nettype wire

/* suspend_smi_control_test.sv */
// Self-checking bench of the suspend and management control.
`default_nettype none

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
`define WAITF(c, n) \
  for (w = 0; w < n && !(c); w++) @(negedge clk); \
  if (!(c)) begin bad_count++; finish_test(); end

module suspend_smi_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ssc_pkg::*;

  logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic suspend_pin_enable = 1'b0, halt_to_suspend = 1'b0;
  logic stop_all_clocks = 1'b0, sys_mgmt_irq_n = 1'b1;
  logic suspend_req_n = 1'b1, halt_exec = 1'b0, core_idle = 1'b0;
  logic wake_evt = 1'b0, smm_exit = 1'b0, pkt_valid = 1'b0;
  logic sys_mgmt_mode, core_clk_stop, all_clk_stop, ext_clk_stop_ok;
  logic suspend_ack_n_o, suspend_ack_n_oe_n, pkt_ready, serial_out;
  logic rx_strobe, full_seen = 1'b0;
  ssc_pkt_t pkt_data = ssc_pkt_t'(8'h00), rx_pkt;
  ssc_pkt_t rx_q[$];
  int bad_count = 0, check_count = 0, w;

  always #10 clk = ~clk;

  ssc_ctrl uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .suspend_pin_enable(suspend_pin_enable),
    .halt_to_suspend(halt_to_suspend), .stop_all_clocks(stop_all_clocks),
    .sys_mgmt_irq_n(sys_mgmt_irq_n), .suspend_req_n(suspend_req_n),
    .halt_exec(halt_exec), .core_idle(core_idle), .wake_evt(wake_evt),
    .smm_exit(smm_exit), .sys_mgmt_mode(sys_mgmt_mode),
    .core_clk_stop(core_clk_stop), .all_clk_stop(all_clk_stop),
    .ext_clk_stop_ok(ext_clk_stop_ok), .suspend_ack_n_o(suspend_ack_n_o),
    .suspend_ack_n_oe_n(suspend_ack_n_oe_n), .pkt_data(pkt_data),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .serial_packet_out(serial_out));

  ssc_rx_model partner (.clk(clk), .sys_rst(sys_rst),
    .serial_in(serial_out), .pkt_out(rx_pkt), .pkt_strobe(rx_strobe));

  always @(posedge clk) begin
    if (rx_strobe === 1'b1) begin
      rx_q.push_back(rx_pkt);
    end
  end

  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_smi();
    @(posedge clk) sys_mgmt_irq_n <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK("mode early", 1'b0, sys_mgmt_mode)
    @(negedge clk);
    `CHK("mode set", 1'b1, sys_mgmt_mode)
    @(posedge clk) sys_mgmt_irq_n <= 1'b1;
    repeat (5) @(negedge clk);
    `CHK("mode held", 1'b1, sys_mgmt_mode)
    @(posedge clk) smm_exit <= 1'b1;
    @(posedge clk) smm_exit <= 1'b0;
    @(negedge clk);
    `CHK("mode exit", 1'b0, sys_mgmt_mode)
  endtask

  task automatic t_freeze();
    @(posedge clk) clk_en <= 1'b0;
    sys_mgmt_irq_n <= 1'b0;
    repeat (6) @(negedge clk);
    `CHK("frozen mode", 1'b0, sys_mgmt_mode)
    `CHK("frozen ready", 1'b0, pkt_ready)
    @(posedge clk) clk_en <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK("thaw early", 1'b0, sys_mgmt_mode)
    @(negedge clk);
    `CHK("thaw mode", 1'b1, sys_mgmt_mode)
    @(posedge clk) smm_exit <= 1'b1;
    @(posedge clk) smm_exit <= 1'b0;
    @(negedge clk);
    `CHK("exit wins", 1'b0, sys_mgmt_mode)
    @(negedge clk);
    `CHK("level reenters", 1'b1, sys_mgmt_mode)
    @(posedge clk) sys_mgmt_irq_n <= 1'b1;
    repeat (3) @(posedge clk);
    smm_exit <= 1'b1;
    @(posedge clk) smm_exit <= 1'b0;
    @(negedge clk);
    `CHK("mode cleared", 1'b0, sys_mgmt_mode)
  endtask

  task automatic t_ignore();
    @(posedge clk) suspend_req_n <= 1'b0;
    core_idle <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK("ignored req", 1'b0, core_clk_stop)
    `CHK("ack floats", 1'b1, suspend_ack_n_oe_n)
    @(posedge clk) suspend_req_n <= 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_pin(input logic all);
    @(posedge clk) suspend_pin_enable <= 1'b1;
    stop_all_clocks <= all;
    core_idle <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("ack driven", 1'b0, suspend_ack_n_oe_n)
    @(posedge clk) suspend_req_n <= 1'b0;
    repeat (8) @(negedge clk);
    `CHK("not drained", 1'b0, core_clk_stop)
    @(posedge clk) core_idle <= 1'b1;
    `WAITF(core_clk_stop, 4)
    `CHK("ack low", 1'b0, suspend_ack_n_o)
    `CHK("all stop", all, all_clk_stop)
    `CHK("ext stop ok", all, ext_clk_stop_ok)
    @(posedge clk) suspend_req_n <= 1'b1;
    `WAITF(suspend_ack_n_o, 6)
    `CHK("resume", 1'b0, core_clk_stop)
  endtask

  task automatic t_halt(input logic hts);
    @(posedge clk) halt_to_suspend <= hts;
    @(posedge clk) halt_exec <= 1'b1;
    @(posedge clk) halt_exec <= 1'b0;
    @(negedge clk);
    `CHK("halt stop", hts, core_clk_stop)
    `CHK("halt ack", ~hts, suspend_ack_n_o)
    @(posedge clk) wake_evt <= 1'b1;
    @(posedge clk) wake_evt <= 1'b0;
    @(negedge clk);
    `CHK("woken", 1'b1, suspend_ack_n_o)
  endtask

  task automatic t_serial();
    logic [7:0] tx[4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) pkt_data <= ssc_pkt_t'(tx[i]);
      pkt_valid <= 1'b1;
      @(negedge clk);
      if (pkt_ready !== 1'b1) full_seen = 1'b1;
      `WAITF(pkt_ready, 40)
    end
    @(posedge clk) pkt_valid <= 1'b0;
    `CHK("buffer full", 1'b1, full_seen)
    `WAITF(rx_q.size() == 4, 80)
    for (int i = 0; i < 4; i++) begin
      `CHK("packet", ssc_pkt_t'(tx[i]), rx_q[i])
    end
    `CHK("idle wire", SER_IDLE_BIT, serial_out)
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK("reset oe", 1'b1, suspend_ack_n_oe_n)
    `CHK("reset mode", 1'b0, sys_mgmt_mode)
    t_smi();
    t_freeze();
    t_ignore();
    t_pin(1'b0);
    t_pin(1'b1);
    t_halt(1'b1);
    t_halt(1'b0);
    t_serial();
    finish_test();
  end
endmodule // suspend_smi_control_test

`default_nettype wire
